// ### pwm_pkg.sv
// Purpose: constants for the pulse width measurement unit
// Assumes: 100 MHz system clock
// Notes: tick length chosen per product variant
package pwm_pkg;
	localparam int PWM_CLK_NS = 10;
	localparam int PWM_PIN_COUNT = 16;
	localparam int PWM_PIN_W = 4;
	localparam int PWM_COUNT_W = 16;
	localparam int PWM_BYTE_W = 8;
	// Tick lengths in picoseconds, one per variant
	localparam int PWM_TICK_10US_PS = 10000000;
	localparam int PWM_TICK_2US_PS = 2000000;
	localparam int PWM_TICK_0U8_PS = 800000;
	localparam int PWM_TICK_0U81_PS = 810000;
	localparam int PWM_CLK_PS = PWM_CLK_NS * 1000;
	localparam int PWM_TICK_CYC_DEF = PWM_TICK_2US_PS / PWM_CLK_PS;
	localparam logic [15:0] PWM_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] PWM_COUNT_ZERO = 16'h0000;
	localparam logic [15:0] PWM_TIMEOUT_RESULT = 16'h0000;
	typedef enum logic [2:0] {
		PWM_IDLE = 3'b000,
		PWM_ARM = 3'b001,
		PWM_WAIT = 3'b010,
		PWM_MEASURE = 3'b011,
		PWM_WRITE = 3'b100,
		PWM_DONE = 3'b101
	} pwm_state_t;
endpackage

// ### pwm_tick_gen.sv
// Purpose: fixed-rate tick strobe for pulse timing
// Assumes: tick_cycles at least one
// Notes: restarts on clear so each phase begins on a whole tick
`timescale 1ns/100ps
module pwm_tick_gen
	import pwm_pkg::*;
#(
	parameter int TICK_CYCLES = PWM_TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic clear,
	output logic tick
);
	localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
	logic [CW-1:0] div;

	always_ff @(posedge clk) begin
		if (!reset_n || clear) begin
			div <= '0;
		end else if (div == LAST) begin
			div <= '0;
		end else begin
			div <= div + CW'(1);
		end
	end

	assign tick = !clear && (div == LAST);
endmodule

// ### pwm_measure.sv
// Purpose: time one pulse on a selected I/O pin in fixed ticks
// Assumes: pins asynchronous to clk; one command at a time
// Notes: count wraps to zero at the top and flags a timeout
// Notes on behaviour
// - Pin index 0 to 15 selected; that pin is input throughout the measurement.
// - Polarity 0 times a low pulse from falling edge; 1 a high pulse from rising.
// - Full pulse width counted in fixed ticks of the variant's length.
// - Wait for the starting edge no longer than the maximum measurable width.
// - After the start, count until pin returns idle, then write the count.
// - No start within the wait, or too long a pulse, writes zero.
// - Internal tick counter is always sixteen bits wide.
// - Byte destination receives only the low eight bits of the count.
`timescale 1ns/100ps
module pwm_measure
	import pwm_pkg::*;
#(
	parameter int TICK_CYCLES = PWM_TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Command
	input wire logic start,
	input wire logic [PWM_PIN_W-1:0] pin_sel,
	input wire logic polarity,
	input wire logic byte_dest,
	output logic busy,
	// I/O pins
	input wire logic [PWM_PIN_COUNT-1:0] pin_in,
	output logic [PWM_PIN_COUNT-1:0] pin_oe,
	// Result
	output logic [PWM_COUNT_W-1:0] result,
	output logic result_valid,
	output logic done
);
	// ********************************
	// Pin synchronisers
	// ********************************
	logic [PWM_PIN_COUNT-1:0] pin_meta;
	logic [PWM_PIN_COUNT-1:0] pin_sync;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ********************************
	// Command capture
	// ********************************
	pwm_state_t state;
	logic [PWM_PIN_W-1:0] sel;
	logic active_level;
	logic to_byte;
	logic level;
	logic level_prev;
	logic [PWM_COUNT_W-1:0] count;
	logic tick;
	logic tick_clear;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sel <= '0;
			active_level <= 1'b0;
			to_byte <= 1'b0;
		end else if (state == PWM_IDLE && start) begin
			sel <= pin_sel;
			active_level <= polarity;
			to_byte <= byte_dest;
		end
	end

	// Every pin is an input; this unit never drives the pads
	assign pin_oe = '0;

	// Selected level, polarity folded so 1 means inside the pulse
	assign level = pin_sync[sel] ~^ active_level;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			level_prev <= 1'b1;
		end else begin
			level_prev <= level;
		end
	end

	// ********************************
	// Edge detect
	// ********************************
	logic start_edge;

	// Fresh edge only; a level already inside the pulse never counts
	assign start_edge = level && !level_prev;

	// ********************************
	// Tick source
	// ********************************
	assign tick_clear = (state == PWM_ARM) || (state == PWM_WAIT && start_edge);

	pwm_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.clear(tick_clear),
		.tick(tick)
	);

	// ********************************
	// Sequencer
	// ********************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= PWM_IDLE;
		end else begin
			case (state)
				PWM_IDLE: begin
					if (start) begin
						state <= PWM_ARM;
					end
				end
				// One cycle so level_prev reflects the new pin
				PWM_ARM: begin
					state <= PWM_WAIT;
				end
				PWM_WAIT: begin
					if (start_edge) begin
						state <= PWM_MEASURE;
					end else if (tick && count == PWM_COUNT_MAX) begin
						state <= PWM_WRITE;
					end
				end
				PWM_MEASURE: begin
					if (!level) begin
						state <= PWM_WRITE;
					end else if (tick && count == PWM_COUNT_MAX) begin
						state <= PWM_WRITE;
					end
				end
				PWM_WRITE: begin
					state <= PWM_DONE;
				end
				PWM_DONE: begin
					state <= PWM_IDLE;
				end
				default: begin
					state <= PWM_IDLE;
				end
			endcase
		end
	end

	// ********************************
	// Tick counter
	// ********************************
	logic timed_out;

	// Wait and pulse share one counter; its wrap at the top is the timeout
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= PWM_COUNT_ZERO;
			timed_out <= 1'b0;
		end else if (state == PWM_ARM) begin
			count <= PWM_COUNT_ZERO;
			timed_out <= 1'b0;
		end else if (state == PWM_WAIT) begin
			if (start_edge) begin
				count <= PWM_COUNT_ZERO;
			end else if (tick) begin
				count <= count + 16'h0001;
				timed_out <= (count == PWM_COUNT_MAX);
			end
		end else if (state == PWM_MEASURE && level && tick) begin
			// Wrapping past the top sets timed_out to mark overrange
			count <= count + 16'h0001;
			timed_out <= (count == PWM_COUNT_MAX);
		end
	end

	// ********************************
	// Result and done
	// ********************************
	logic [PWM_COUNT_W-1:0] next_result;

	always_comb begin
		if (timed_out) begin
			next_result = PWM_TIMEOUT_RESULT;
		end else if (to_byte) begin
			next_result = {{(PWM_COUNT_W-PWM_BYTE_W){1'b0}}, count[PWM_BYTE_W-1:0]};
		end else begin
			next_result = count;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			result <= PWM_COUNT_ZERO;
			result_valid <= 1'b0;
		end else begin
			result_valid <= (state == PWM_WRITE);
			if (state == PWM_WRITE) begin
				result <= next_result;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			done <= 1'b0;
		end else begin
			done <= result_valid;
		end
	end

	assign busy = (state != PWM_IDLE);
endmodule

// ### pwm_measure_monitor.sv
// Purpose: port checks for pwm_measure
// Assumes: one clock, sync active-low reset
// Notes: sees ports only
`timescale 1ns/100ps
module pwm_measure_mon
	import pwm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched
	input wire logic start,
	input wire logic busy,
	input wire logic byte_dest,
	input wire logic [PWM_PIN_COUNT-1:0] pin_oe,
	input wire logic [PWM_COUNT_W-1:0] result,
	input wire logic result_valid,
	input wire logic done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pins_input: assert property (pin_oe == '0) else $error("pin driven");
	a_start_busy: assert property (start && !busy |=> busy) else $error("no busy");
	a_done_follows: assert property (result_valid |=> done) else $error("done late");
	a_done_cause: assert property (done |-> $past(result_valid)) else $error("stray done");
	a_idle_after: assert property (done |-> !busy) else $error("busy stuck");
	a_busy_holds: assert property (busy && !result_valid |=> busy) else $error("busy drop");
	a_result_held: assert property (!result_valid |-> $stable(result)) else $error("drift");
	a_byte_low: assert property (result_valid && byte_dest |-> result[15:8] == 8'h00)
		else $error("byte high");
endmodule
bind pwm_measure pwm_measure_mon i_mon(.clk(clk), .reset_n(reset_n), .start(start),
	.busy(busy), .byte_dest(byte_dest), .pin_oe(pin_oe), .result(result),
	.result_valid(result_valid), .done(done));

// ### pwm_pulse_src.sv
// Purpose: external pulse source on the pins
// Assumes: pulse length in clk cycles
// Notes: unselected pins toggle to expose wrong pin choice
`timescale 1ns/100ps
module pwm_pulse_src (
	// Clock and control
	input wire logic clk,
	input wire logic go,
	input wire logic [3:0] sel,
	input wire logic pol,
	input wire logic [16:0] width,
	// Pins
	output logic [15:0] pin_in
);
	logic [16:0] n = 17'h00000;
	logic noise = 1'b0;
	always_ff @(posedge clk) begin
		noise <= !noise;
		n <= go ? width : (n != 17'h00000 ? n - 17'h00001 : n);
	end
	always_comb begin
		pin_in = {8{noise, !noise}};
		pin_in[sel] = (n != 0) ? pol : !pol;
	end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for pwm_measure
// Assumes: one tick per clock for short runs
// Notes: one wait timeout costs 65536 cycles
`timescale 1ns/100ps
module tb_top;
	import pwm_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic polarity = 1'b0;
	logic byte_dest = 1'b0;
	logic go = 1'b0;
	logic [PWM_PIN_W-1:0] pin_sel = 4'h0;
	logic [16:0] width = 17'h00000;
	logic busy, result_valid, done;
	logic [PWM_PIN_COUNT-1:0] pin_in, pin_oe;
	logic [PWM_COUNT_W-1:0] result;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	int rows[5][5] = '{'{3,1,0,30,30}, '{0,0,0,57,57}, '{15,1,0,2,2}, '{9,0,1,300,44},
		'{6,1,0,0,0}};
	initial forever #5 clk = ~clk;
	pwm_measure #(.TICK_CYCLES(1)) i_dut(.clk(clk), .reset_n(reset_n), .start(start),
		.pin_sel(pin_sel), .polarity(polarity), .byte_dest(byte_dest), .busy(busy),
		.pin_in(pin_in), .pin_oe(pin_oe), .result(result), .result_valid(result_valid),
		.done(done));
	pwm_pulse_src i_src(.clk(clk), .go(go), .sel(pin_sel), .pol(polarity), .width(width),
		.pin_in(pin_in));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (failures == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic fire(input int w);
		width = 17'(w);
		go = 1'b1;
		tick(1);
		go = 1'b0;
	endtask
	// Pre above zero starts the command inside a running pulse
	task automatic run(input int p, input int pl, input int bd, input int w, input int pre,
		input int want);
		logic ok;
		pin_sel = 4'(p);
		polarity = 1'(pl);
		byte_dest = 1'(bd);
		tick(3);
		if (pre > 0) begin
			fire(pre);
			tick(pre / 2);
		end
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(pre + 4);
		chk("busy on", 16'(busy), 16'h0001);
		chk("oe", pin_oe, 16'h0000);
		if (w > 0) fire(w);
		for (int k = 0; k < 70000 && result_valid !== 1'b1; k++) tick(1);
		// Sync delay makes the count one tick uncertain
		ok = (result >= 16'(want - 1)) && (result <= 16'(want + 1));
		if (w == 0) chk("timeout", result, 16'h0000);
		else chk("width", 16'(ok), 16'h0001);
		tick(1);
		chk("done", 16'(done), 16'h0001);
		tick(1);
		chk("busy", 16'(busy), 16'h0000);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		tick(20);
		chk("reset", result, 16'h0000);
		reset_n = 1'b1;
		tick(1);
		foreach (rows[i]) run(rows[i][0], rows[i][1], rows[i][2], rows[i][3], 0, rows[i][4]);
		run(5, 1, 0, 60, 40, 60);
		// Reset in mid-pulse drops the command and the result
		pin_sel = 4'h2;
		polarity = 1'b1;
		tick(3);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(4);
		fire(50);
		tick(10);
		reset_n = 1'b0;
		tick(2);
		chk("rst busy", 16'(busy), 16'h0000);
		chk("rst result", result, 16'h0000);
		chk("rst done", 16'(done), 16'h0000);
		reset_n = 1'b1;
		tick(60);
		run(2, 0, 0, 12, 0, 12);
		wrap_up();
	end
endmodule
